// [inc/tp_pkg.sv]
// package: constants, states and carriers for the twisted pair interface
package tp_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ           = 100;
  localparam int SQL_WINDOW_NS     = 150;
  localparam int SQL_WINDOW_CYC    = (SQL_WINDOW_NS * CLK_MHZ) / 1000;
  localparam int LINK_PULSE_NS     = 100;
  localparam int LINK_PULSE_CYC    = (LINK_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int LINK_PERIOD_MS    = 16;
  localparam int LINK_PERIOD_CYC   = LINK_PERIOD_MS * CLK_MHZ * 1000;
  localparam int LINK_LOSS_MS      = 100;
  localparam int LINK_LOSS_CYC     = LINK_LOSS_MS * CLK_MHZ * 1000;
  localparam int JABBER_MS         = 26;
  localparam int JABBER_CYC        = JABBER_MS * CLK_MHZ * 1000;
  localparam int UNJAB_MS          = 750;
  localparam int UNJAB_CYC         = UNJAB_MS * CLK_MHZ * 1000;
  localparam int SQE_DELAY_NS      = 1000;
  localparam int SQE_DELAY_CYC     = (SQE_DELAY_NS * CLK_MHZ) / 1000;
  localparam int SQE_FREQ_MHZ      = 10;
  localparam int SQE_HALF_CYC      = CLK_MHZ / (2 * SQE_FREQ_MHZ);
  localparam int SQE_CYCLES        = 10;
  localparam int PREEMPH_NS        = 50;
  localparam int PREEMPH_CYC       = (PREEMPH_NS * CLK_MHZ) / 1000;
  localparam int BIT_NS            = 100;
  localparam int BIT_CYC           = (BIT_NS * CLK_MHZ) / 1000;
  localparam int COL_TX_BITS       = 7;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {SQ_IDLE, SQ_OPP, SQ_ORIG, SQ_VALID} squelch_e;

  // comparator outputs from the analog front end, all three level sets
  typedef struct packed {
    logic pos_std;
    logic neg_std;
    logic pos_low;
    logic neg_low;
    logic pos_rx;
    logic neg_rx;
  } tp_receive_in_s;

  typedef struct packed {
    logic tx_p;
    logic tx_n;
    logic txd_p;
    logic txd_n;
  } tp_transmit_out_s;

  typedef struct packed {
    logic receive_activity_indicator;
    logic transmit_activity_indicator;
    logic collision_indicator;
    logic link_good_indicator;
    logic polarity_indicator;
  } indicators_s;

endpackage

// [logic/squelch_qual.sv]
// module: smart receive squelch qualification and end of packet
`timescale 1ns/10ps
module squelch_qual
  import tp_pkg::*;
(
  input  wire logic           clk_sys_i,
  input  wire logic           rst_i,
  input  wire logic           enable_i,
  input  wire logic           squelch_threshold_select_i,
  input  wire tp_receive_in_s tp_receive_in_i,
  output logic                data_valid_o,
  output logic                polarity_o
);
  typedef struct packed {
    squelch_e    st;
    logic [15:0] cnt;
    logic        first_pos;
    logic        pol;
  } sq_state_s;

  sq_state_s cur_ff;
  sq_state_s nxt_cur;
  logic      hit_p;
  logic      hit_n;

  // ------------------------------------------------------------
  // qualification sequence
  // ------------------------------------------------------------
  always_comb begin
    // only the level differs between modes; sequence is shared
    hit_p = squelch_threshold_select_i ? tp_receive_in_i.pos_low : tp_receive_in_i.pos_std;
    hit_n = squelch_threshold_select_i ? tp_receive_in_i.neg_low : tp_receive_in_i.neg_std;
    nxt_cur = cur_ff;
    nxt_cur.cnt = cur_ff.cnt + 16'h0001;
    unique case (cur_ff.st)
      SQ_IDLE: begin
        nxt_cur.cnt = 16'h0000;
        if (hit_p || hit_n) begin
          nxt_cur.st = SQ_OPP;
          nxt_cur.first_pos = hit_p;
        end
      end
      SQ_OPP: begin
        if (cur_ff.first_pos ? hit_n : hit_p) begin
          nxt_cur.st = SQ_ORIG;
          nxt_cur.cnt = 16'h0000;
        end else if (cur_ff.cnt >= 16'(SQL_WINDOW_CYC - 1)) begin
          nxt_cur.st = SQ_IDLE;
        end
      end
      SQ_ORIG: begin
        if (cur_ff.first_pos ? hit_p : hit_n) begin
          nxt_cur.st = SQ_VALID;
          nxt_cur.cnt = 16'h0000;
          nxt_cur.pol = cur_ff.first_pos;
        end else if (cur_ff.cnt >= 16'(SQL_WINDOW_CYC - 1)) begin
          nxt_cur.st = SQ_IDLE;
        end
      end
      SQ_VALID: begin
        // lowered receive levels keep noise from ending the packet
        if (tp_receive_in_i.pos_rx || tp_receive_in_i.neg_rx) begin
          nxt_cur.cnt = 16'h0000;
        end else if (cur_ff.cnt >= 16'(SQL_WINDOW_CYC)) begin
          nxt_cur.st = SQ_IDLE;
        end
      end
    endcase
    if (!enable_i) begin
      nxt_cur.st = SQ_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cur_ff <= '{st: SQ_IDLE, cnt: 16'h0000, first_pos: 1'b0, pol: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign data_valid_o = (cur_ff.st == SQ_VALID);
  assign polarity_o   = cur_ff.pol;
endmodule

// [logic/jabber_ctl.sv]
// module: jabber timer and unjab interval
`timescale 1ns/10ps
module jabber_ctl
  import tp_pkg::*;
#(
  parameter int JABBER_CYCLES = JABBER_CYC,
  parameter int UNJAB_CYCLES  = UNJAB_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic tx_enable_i,
  output logic      jabbered_o
);
  typedef struct packed {
    logic        jab;
    logic [31:0] cnt;
  } jab_state_s;

  jab_state_s cur_ff;
  jab_state_s nxt_cur;

  // ------------------------------------------------------------
  // timer
  // ------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    if (!cur_ff.jab) begin
      if (!tx_enable_i) begin
        nxt_cur.cnt = 32'h00000000;
      end else if (cur_ff.cnt >= 32'(JABBER_CYCLES - 1)) begin
        nxt_cur.jab = 1'b1;
        nxt_cur.cnt = 32'h00000000;
      end else begin
        nxt_cur.cnt = cur_ff.cnt + 32'h00000001;
      end
    end else begin
      // any transmit enable restarts the unjab wait
      if (tx_enable_i) begin
        nxt_cur.cnt = 32'h00000000;
      end else if (cur_ff.cnt >= 32'(UNJAB_CYCLES - 1)) begin
        nxt_cur.jab = 1'b0;
        nxt_cur.cnt = 32'h00000000;
      end else begin
        nxt_cur.cnt = cur_ff.cnt + 32'h00000001;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cur_ff <= '{jab: 1'b0, cnt: 32'h00000000};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign jabbered_o = cur_ff.jab;
endmodule

// [logic/twisted_pair_interface.sv]
// module: twisted pair interface digital control, top level
`timescale 1ns/10ps
// ------------------------------------------------------------
// How it works
// - at packet start, pulses below the selected squelch level are rejected
// - opposite polarity level must follow within 150 ns, else noise
// - original polarity level must recur within a further 150 ns
// - valid data raised only after all three checks; a missed check resets the sequencer
// - valid held until no level crossed for over 150 ns: end of packet
// - lowered thresholds apply while qualified data is received
// - select input picks standard or reduced levels, same sequence and timing
// - collision when receive and transmit are active together
// - collision reported immediately if receiving first
// - if transmitting first, report after seven bits received in collision
// - collision report held for the whole collision
// - about 1 us after each transmit not cut by jabber, ten 10 MHz heartbeat cycles
// - idle transmit sends 100 ns link pulse on positive output every 16 ms
// - no valid remote link pulses disables transmit, receive and collision
// - link good indicator active while link judged good
// - link check disable input bypasses link integrity
// - transmit active over 26 ms disables the transmit outputs
// - after jabber, re-enable only after enable low about 750 ms
// - true, complement and 50 ns delayed copies drive pre-emphasis
// - separate receive, transmit, collision, link and polarity indicators
// ------------------------------------------------------------
module twisted_pair_interface
  import tp_pkg::*;
#(
  parameter int LINK_PERIOD_CYCLES = LINK_PERIOD_CYC,
  parameter int LINK_LOSS_CYCLES   = LINK_LOSS_CYC,
  parameter int JABBER_CYCLES      = JABBER_CYC,
  parameter int UNJAB_CYCLES       = UNJAB_CYC
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             squelch_threshold_select_i,
  input  wire logic             link_check_disable_i,
  input  wire tp_receive_in_s   tp_receive_in_i,
  input  wire logic             link_pulse_seen_i,
  input  wire logic             tx_enable_i,
  input  wire logic             tx_data_i,
  output tp_transmit_out_s      tp_transmit_out_o,
  output logic                  carrier_sense_o,
  output logic                  collision_o,
  output indicators_s           indicators_o
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [PREEMPH_CYC-1:0] dly_p;
    logic [PREEMPH_CYC-1:0] dly_n;
    tp_transmit_out_s       txo;
    logic                   col_raw_q;
    logic                   col_from_tx;
    logic                   col_rep;
    logic [3:0]             col_bits;
    logic [7:0]             bit_cnt;
    logic                   tx_q;
    logic                   sqe_wait;
    logic                   sqe_run;
    logic [7:0]             sqe_cnt;
    logic [4:0]             sqe_cyc;
    logic                   sqe_lvl;
    logic [31:0]            lp_cnt;
    logic [7:0]             lp_w;
    logic [31:0]            loss_cnt;
    logic                   link_ok;
    logic                   cs;
    logic                   col_o;
    indicators_s            ind;
  } top_state_s;

  top_state_s cur_ff;
  top_state_s nxt_cur;
  logic       rx_valid;
  logic       rx_pol;
  logic       jabbered;
  logic       path_en;
  logic       tx_act;
  logic       col_raw;

  // ------------------------------------------------------------
  // sub blocks
  // ------------------------------------------------------------
  squelch_qual u_squelch (
    .clk_sys_i                  (clk_sys_i),
    .rst_i                      (rst_i),
    .enable_i                   (path_en),
    .squelch_threshold_select_i (squelch_threshold_select_i),
    .tp_receive_in_i            (tp_receive_in_i),
    .data_valid_o               (rx_valid),
    .polarity_o                 (rx_pol)
  );

  jabber_ctl #(
    .JABBER_CYCLES (JABBER_CYCLES),
    .UNJAB_CYCLES  (UNJAB_CYCLES)
  ) u_jabber (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .tx_enable_i (tx_enable_i),
    .jabbered_o  (jabbered)
  );

  assign path_en = cur_ff.link_ok || link_check_disable_i;
  assign tx_act  = tx_enable_i && path_en && !jabbered;
  assign col_raw = rx_valid && tx_act;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.tx_q = tx_act;
    nxt_cur.col_raw_q = col_raw;

    // link integrity: each seen pulse restarts the loss timer
    if (link_pulse_seen_i) begin
      nxt_cur.loss_cnt = 32'h00000000;
      nxt_cur.link_ok = 1'b1;
    end else if (cur_ff.loss_cnt >= 32'(LINK_LOSS_CYCLES - 1)) begin
      nxt_cur.link_ok = 1'b0;
    end else begin
      nxt_cur.loss_cnt = cur_ff.loss_cnt + 32'h00000001;
    end

    // collision: who was first decides when it is reported
    if (!col_raw) begin
      nxt_cur.col_rep = 1'b0;
      nxt_cur.col_bits = 4'h0;
      nxt_cur.bit_cnt = 8'h00;
    end else if (!cur_ff.col_raw_q) begin
      nxt_cur.col_from_tx = cur_ff.tx_q && !rx_valid ? 1'b1 : cur_ff.tx_q;
      nxt_cur.col_rep = !cur_ff.tx_q;
      nxt_cur.bit_cnt = 8'h00;
    end else if (!cur_ff.col_rep) begin
      if (cur_ff.bit_cnt >= 8'(BIT_CYC - 1)) begin
        nxt_cur.bit_cnt = 8'h00;
        nxt_cur.col_bits = cur_ff.col_bits + 4'h1;
        if (cur_ff.col_bits >= 4'(COL_TX_BITS - 1)) begin
          nxt_cur.col_rep = 1'b1;
        end
      end else begin
        nxt_cur.bit_cnt = cur_ff.bit_cnt + 8'h01;
      end
    end

    // heartbeat after each transmit end not caused by jabber
    if (cur_ff.tx_q && !tx_act && !jabbered) begin
      nxt_cur.sqe_wait = 1'b1;
      nxt_cur.sqe_cnt = 8'h00;
    end else if (cur_ff.sqe_wait) begin
      if (cur_ff.sqe_cnt >= 8'(SQE_DELAY_CYC - 1)) begin
        nxt_cur.sqe_wait = 1'b0;
        nxt_cur.sqe_run = 1'b1;
        nxt_cur.sqe_cnt = 8'h00;
        nxt_cur.sqe_cyc = 5'h00;
        nxt_cur.sqe_lvl = 1'b1;
      end else begin
        nxt_cur.sqe_cnt = cur_ff.sqe_cnt + 8'h01;
      end
    end else if (cur_ff.sqe_run) begin
      if (cur_ff.sqe_cnt >= 8'(SQE_HALF_CYC - 1)) begin
        nxt_cur.sqe_cnt = 8'h00;
        nxt_cur.sqe_lvl = !cur_ff.sqe_lvl;
        nxt_cur.sqe_cyc = cur_ff.sqe_cyc + 5'h01;
        if (cur_ff.sqe_cyc >= 5'(2 * SQE_CYCLES - 1)) begin
          nxt_cur.sqe_run = 1'b0;
          nxt_cur.sqe_lvl = 1'b0;
        end
      end else begin
        nxt_cur.sqe_cnt = cur_ff.sqe_cnt + 8'h01;
      end
    end

    // link pulse generator, held off while data is sent
    if (tx_enable_i) begin
      nxt_cur.lp_cnt = 32'h00000000;
      nxt_cur.lp_w = 8'h00;
    end else if (cur_ff.lp_cnt >= 32'(LINK_PERIOD_CYCLES - 1)) begin
      nxt_cur.lp_cnt = 32'h00000000;
      nxt_cur.lp_w = 8'(LINK_PULSE_CYC);
    end else begin
      nxt_cur.lp_cnt = cur_ff.lp_cnt + 32'h00000001;
      if (cur_ff.lp_w != 8'h00) begin
        nxt_cur.lp_w = cur_ff.lp_w - 8'h01;
      end
    end

    // transmit pins; jabber forces both lines idle
    nxt_cur.txo.tx_p = 1'b0;
    nxt_cur.txo.tx_n = 1'b0;
    if (tx_act) begin
      nxt_cur.txo.tx_p = tx_data_i;
      nxt_cur.txo.tx_n = !tx_data_i;
    end else if (nxt_cur.lp_w != 8'h00 && !jabbered) begin
      nxt_cur.txo.tx_p = 1'b1;
    end
    // the delay line is a shift register, so its length tracks the clock rate
    nxt_cur.dly_p = {cur_ff.dly_p[PREEMPH_CYC-2:0], nxt_cur.txo.tx_p};
    nxt_cur.dly_n = {cur_ff.dly_n[PREEMPH_CYC-2:0], nxt_cur.txo.tx_n};
    // last tap of the line, so the copy trails the live pins by the full delay
    nxt_cur.txo.txd_p = cur_ff.dly_p[PREEMPH_CYC-1];
    nxt_cur.txo.txd_n = cur_ff.dly_n[PREEMPH_CYC-1];

    // registered here so the collision pin comes straight from a flip-flop
    nxt_cur.col_o = nxt_cur.col_rep || nxt_cur.sqe_lvl;
    nxt_cur.cs = rx_valid || cur_ff.sqe_run;
    // indicators
    nxt_cur.ind.receive_activity_indicator  = rx_valid;
    nxt_cur.ind.transmit_activity_indicator = tx_act;
    nxt_cur.ind.collision_indicator         = nxt_cur.col_rep || nxt_cur.sqe_lvl;
    nxt_cur.ind.link_good_indicator         = nxt_cur.link_ok;
    nxt_cur.ind.polarity_indicator          = rx_pol;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign tp_transmit_out_o = cur_ff.txo;
  assign carrier_sense_o   = cur_ff.cs;
  assign collision_o       = cur_ff.col_o;
  assign indicators_o      = cur_ff.ind;
endmodule

// [test/tp_remote.sv]
// remote twisted pair unit model: squelch pulses, data bursts, link pulses
`timescale 1ns/10ps
module tp_remote
  import tp_pkg::*;
(
  input  wire logic      clk_sys_i,
  input  wire logic      link_on_i,
  output tp_receive_in_s rx_o,
  output logic           link_pulse_o
);
  int lc = 0;
  initial begin
    rx_o = '0;
    link_pulse_o = 1'b0;
  end
  // ------------------------------------------------------------
  // link pulses, spaced well inside the loss window
  // ------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    lc <= (lc == 149) ? 0 : lc + 1;
    link_pulse_o <= link_on_i && lc == 0;
  end
  // level -1 idle, 0 lowered only, 1 reduced, 2 standard; a big swing trips all lower ones
  task automatic hold(input int lv, input bit ng, input int n);
    tp_receive_in_s v;
    v = '0;
    if (lv >= 0) {v.pos_rx, v.neg_rx} = {!ng, ng};
    if (lv >= 1) {v.pos_low, v.neg_low} = {!ng, ng};
    if (lv >= 2) {v.pos_std, v.neg_std} = {!ng, ng};
    repeat (n) begin
      rx_o <= v;
      @(posedge clk_sys_i);
    end
  endtask
  // three start pulses, then a body on the lowered comparators only
  task automatic qualify(input int lv, input bit ng, input int g1, input int g2, input int b);
    hold(lv, ng, 2);
    hold(-1, 0, g1 - 2);
    hold(lv, !ng, 2);
    hold(-1, 0, g2 - 2);
    hold(lv, ng, 2);
    repeat (b) begin
      hold(0, 0, 5);
      hold(0, 1, 5);
    end
    hold(-1, 0, 1);
  endtask
endmodule

// [test/tp_assertions.sv]
// checker: port timing relations of the twisted pair interface
`timescale 1ns/10ps
module tp_assertions
  import tp_pkg::*;
#(
  parameter int JABBER_CYCLES = JABBER_CYC
) (
  input wire logic             clk_sys_i,
  input wire logic             rst_i,
  input wire logic             squelch_threshold_select_i,
  input wire logic             link_check_disable_i,
  input wire tp_receive_in_s   tp_receive_in_i,
  input wire logic             link_pulse_seen_i,
  input wire logic             tx_enable_i,
  input wire logic             tx_data_i,
  input wire tp_transmit_out_s tp_transmit_out_o,
  input wire logic             carrier_sense_o,
  input wire logic             collision_o,
  input wire indicators_s      indicators_o
);
  wire txp = tp_transmit_out_o.tx_p;
  wire txn = tp_transmit_out_o.tx_n;
  wire lg  = indicators_o.link_good_indicator;
  int  jc;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // saturates so a long jabber never wraps back under the limit
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !tx_enable_i)
      jc <= 0;
    else if (jc < JABBER_CYCLES + 100)
      jc <= jc + 1;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence link_down;
    (!lg && !link_check_disable_i)[*3];
  endsequence
  sequence rx_then_tx;
    carrier_sense_o && !tx_enable_i ##1 tx_enable_i && carrier_sense_o && lg;
  endsequence
  sequence pulse_shape;
    (txp && !txn)[*8] ##1 txp[*2] ##1 !txp;
  endsequence
  a_delay_copy:
  assert property (tp_transmit_out_o.txd_p == $past(txp, 5)
    && tp_transmit_out_o.txd_n == $past(txn, 5)) else $error("delayed copy wrong");
  a_tx_exclusive:
  assert property (!(txp && txn)) else $error("both transmit outputs high");
  a_link_gate:
  assert property (link_down |-> !carrier_sense_o) else $error("receive with link down");
  a_valid_hold:
  assert property (carrier_sense_o && lg && (tp_receive_in_i.pos_rx || tp_receive_in_i.neg_rx)
    |=> carrier_sense_o) else $error("valid dropped during data");
  a_col_rx_first:
  assert property (rx_then_tx |-> ##[0:3] collision_o) else $error("late collision report");
  a_col_tx_first:
  assert property ($rose(carrier_sense_o) && tx_enable_i && !collision_o
    |=> (!collision_o)[*8]) else $error("early collision report");
  a_jab_cut:
  assert property (jc > JABBER_CYCLES + 8 |-> tp_transmit_out_o == '0)
    else $error("transmit not cut by jabber");
  a_link_pulse:
  assert property ($rose(txp) && !tx_enable_i && !$past(tx_enable_i) && !$past(tx_enable_i, 2)
    |-> pulse_shape or (##[0:9] tx_enable_i)) else $error("link pulse shape");
endmodule
bind twisted_pair_interface tp_assertions #(.JABBER_CYCLES(JABBER_CYCLES)) tp_assertions_i (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .squelch_threshold_select_i(squelch_threshold_select_i),
  .link_check_disable_i(link_check_disable_i), .tp_receive_in_i(tp_receive_in_i),
  .link_pulse_seen_i(link_pulse_seen_i), .tx_enable_i(tx_enable_i), .tx_data_i(tx_data_i),
  .tp_transmit_out_o(tp_transmit_out_o), .carrier_sense_o(carrier_sense_o),
  .collision_o(collision_o), .indicators_o(indicators_o));

// [test/tb_top.sv]
// self-checking bench for the twisted pair interface
`timescale 1ns/10ps
module tb_top;
  import tp_pkg::*;
  localparam int LP = 200;
  localparam int LL = 1000;
  localparam int JB = 500;
  localparam int UJ = 800;
  logic             clk_sys_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             sel = 1'b0;
  logic             dis = 1'b0;
  logic             lnk = 1'b0;
  logic             tx_en = 1'b0;
  logic             tx_d = 1'b0;
  logic             d_q = 1'b0;
  logic             seen = 1'b0;
  logic [31:0]      seed = 32'hA7F2;
  tp_receive_in_s   rx;
  logic             lps;
  tp_transmit_out_s txo;
  logic             crs;
  logic             col;
  indicators_s      ind;
  int               fail_count = 0;
  int               n_tests = 0;
  int               k, r, i, c;
  int               t[16];
  bit               ex;
  bit               pg;
  int               lt[5] = '{2, 1, 0, 2, 2};
  int               g1[5] = '{4, 6, 4, 20, 4};
  int               g2[5] = '{6, 4, 4, 5, 20};
  tp_remote tp_remote_i (.clk_sys_i(clk_sys_i), .link_on_i(lnk), .rx_o(rx), .link_pulse_o(lps));
  twisted_pair_interface #(.LINK_PERIOD_CYCLES(LP), .LINK_LOSS_CYCLES(LL), .JABBER_CYCLES(JB),
    .UNJAB_CYCLES(UJ)) twisted_pair_interface_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .squelch_threshold_select_i(sel), .link_check_disable_i(dis), .tp_receive_in_i(rx),
    .link_pulse_seen_i(lps), .tx_enable_i(tx_en), .tx_data_i(tx_d), .tp_transmit_out_o(txo),
    .carrier_sense_o(crs), .collision_o(col), .indicators_o(ind));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // data is random only while enabled, so idle checks see a quiet line
  always @(posedge clk_sys_i) begin
    seed <= xs(seed);
    tx_d <= tx_en & seed[3];
    d_q <= tx_d;
  end
  always @(negedge clk_sys_i) if (crs === 1'b1) seen = 1'b1;
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input bit ok, input string m);
    n_tests++;
    if (!ok) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic pe(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  function automatic logic sg(input int s);
    case (s)
      0: return crs;
      1: return col;
      2: return txo.tx_p;
      default: return ind.link_good_indicator;
    endcase
  endfunction
  task automatic wt(input int s, input logic v, input int n, input bit must);
    for (k = 0; k < n; k++) begin
      @(negedge clk_sys_i);
      if (sg(s) === v) break;
    end
    if (must && k == n) begin
      chk(0, "wait ran out");
      stop_test();
    end
  endtask
  task automatic rises(input int s, input int n);
    logic p;
    p = 1'b0;
    c = 0;
    for (int j = 0; j < n; j++) begin
      @(negedge clk_sys_i);
      if (sg(s) === 1'b1 && !p && c < 16) t[c++] = j;
      p = (sg(s) === 1'b1);
    end
    @(posedge clk_sys_i);
  endtask
  task automatic act(input int n);
    c = 0;
    repeat (n) begin
      @(negedge clk_sys_i);
      if (txo !== '0) c++;
    end
    @(posedge clk_sys_i);
  endtask
  task automatic pkt(input int lv, input int a, input int b, input int n);
    seen = 1'b0;
    pg = seed[0];
    tp_remote_i.qualify(lv, pg, a, b, n);
  endtask
  initial begin
    #300000;
    chk(0, "run too long");
    stop_test();
  end
  initial begin
    pe(12);
    rst_i <= 1'b0;
    @(negedge clk_sys_i);
    chk(txo === '0 && crs === 1'b0 && col === 1'b0 && ind === '0, "reset"); // RESET
    pe(1);
    lnk <= 1'b1;
    wt(3, 1'b1, 400, 1);
    pe(1);
    for (r = 0; r < 10; r++) begin
      sel <= r[0];
      i = r / 2;
      ex = lt[i] >= (r[0] ? 1 : 2) && g1[i] <= SQL_WINDOW_CYC && g2[i] <= SQL_WINDOW_CYC;
      pe(2);
      pkt(lt[i], g1[i], g2[i], 4);
      @(negedge clk_sys_i);
      chk(seen === ex && crs === ex && ind.receive_activity_indicator === ex, "squelch");
      if (ex) begin
        chk(ind.polarity_indicator === !pg, "polarity");
        wt(0, 1'b0, 40, 1);
        chk(k >= 14 && k <= 20, "end of packet");
      end
      pe(30);
    end
    $display("test done: squelch");
    tx_en <= 1'b1;
    pe(3);
    repeat (40) begin
      @(negedge clk_sys_i);
      chk(txo.tx_p === d_q && txo.tx_n === !d_q && ind.transmit_activity_indicator === 1'b1, "tx");
    end
    pe(1);
    tx_en <= 1'b0;
    rises(1, 250);
    chk(c == SQE_CYCLES && t[1] - t[0] == 2 * SQE_HALF_CYC, "heartbeat count");
    chk(t[0] >= SQE_DELAY_CYC - 10 && t[0] <= SQE_DELAY_CYC + 15, "heartbeat delay");
    rises(2, 2 * LP + 20);
    chk(c >= 2 && t[1] - t[0] == LP, "link pulse period");
    $display("test done: transmit");
    fork
      pkt(2, 4, 4, 30);
      begin
        pe(60);
        tx_en <= 1'b1;
        wt(1, 1'b1, 3, 0);
        chk(k < 3 && ind.collision_indicator === 1'b1, "rx first");
        act(0);
        rises(1, 100);
        chk(c == 1 && t[0] == 0, "collision held");
        tx_en <= 1'b0;
      end
    join
    pe(300);
    tx_en <= 1'b1;
    pe(5);
    fork
      pkt(2, 4, 4, 20);
      begin
        wt(0, 1'b1, 40, 1);
        wt(1, 1'b1, 120, 1);
        chk(k >= COL_TX_BITS * BIT_CYC - 10 && k <= COL_TX_BITS * BIT_CYC + 15, "tx first");
      end
    join
    tx_en <= 1'b0;
    pe(300);
    $display("test done: collision");
    lnk <= 1'b0;
    wt(3, 1'b0, LL + 300, 1);
    pe(1);
    pkt(2, 4, 4, 4);
    chk(seen === 1'b0, "link lost");
    dis <= 1'b1;
    pe(2);
    pkt(2, 4, 4, 4);
    chk(seen === 1'b1, "link check off");
    pe(30);
    dis <= 1'b0;
    lnk <= 1'b1;
    wt(3, 1'b1, 400, 1);
    $display("test done: link");
    pe(1);
    tx_en <= 1'b1;
    act(JB - 20);
    chk(c > 0, "tx before jabber");
    act(40);
    act(100);
    chk(c == 0, "jabber cut");
    tx_en <= 1'b0;
    act(UJ / 2);
    tx_en <= 1'b1;
    act(12);
    act(20);
    chk(c == 0, "still jabbered");
    tx_en <= 1'b0;
    act(UJ + 100);
    tx_en <= 1'b1;
    act(30);
    chk(c > 0, "unjabbered");
    $display("test done: jabber");
    stop_test();
  end
endmodule
